// ===== verilog/crs_reset_sequencer.sv
// Reset sequencer driving the six reset domains of a four-core cluster
`include "crs_params.svh"
`default_nettype none

// Summary of operation
// - Unit plus debug APB reset: that core's unit and debug APB low only.
// - Unit plus core debug reset: that core's unit and debug low only.
// - Run mode: every reset pin high, nothing held in reset.
// - Power-on reset asserts power-on reset; other core resets optional.
// - Debug APB reset never asserted while any core is being debugged.
// - Without the unit, its reset pins are tied high.
// - At power arrival assert power-on, shared-cache and debug APB together.
// - Full power-on holds 16 core cycles and 16 debug cycles.
// - Shared-cache reset released no later than any core reset.
// - Single-core power-on only while powered; held 16 core cycles.
// - Soft reset waits for preparation and the core idle indicator.
// - Clamps released only after 5 cycles of asserted soft reset.
// - Soft reset holds the core reset low at least 16 core cycles.
// - Core and unit resets of a soft reset release in one cycle.
// - Single-core setups may skip the coherency bit preparation step.
// - Unit reset held low at least 16 core cycles.
// - Core debug reset held low at least 16 core cycles.
// - Debug APB reset held low at least 16 debug-clock cycles.
// - Single-core soft reset keeps power-on, debug and shared resets high.
module crs_reset_sequencer
  import crs_pkg::*;
#(
  parameter bit UNIT_PRESENT = 1'b1,
  parameter bit SINGLE_CORE = 1'b0
) (
  input wire logic clk_i,
  input wire logic sys_rst_i,
  input wire logic debug_apb_clock_i,
  input wire logic req_i,
  input wire crs_cmd_t cmd_i,
  input wire logic [1:0] core_sel_i,
  input wire logic opt_resets_i,
  input wire logic [3:0] core_active_i,
  input wire logic [3:0] core_debugged_i,
  input wire logic [3:0] core_powered_i,
  input wire logic [3:0] core_idle_standby_i,
  input wire logic prep_done_i,
  output crs_resets_t resets_o,
  output logic clamp_release_o,
  output logic busy_o,
  output logic done_o,
  output logic refused_o
);

  // ----------------------------------------------------------------
  // Pattern decoding
  // ----------------------------------------------------------------

  function automatic logic [3:0] mask_of(crs_cmd_t c, logic [1:0] sel);
    logic [3:0] m;
    m = 4'h0;
    case (c)
      CMD_FULL_POWERON,
      CMD_SOFT_ALL,
      CMD_DEBUG_ALL: m = `CRS_ALL_CORES;
      default: m[sel] = 1'b1;
    endcase
    return m;
  endfunction

  function automatic crs_resets_t pattern_of(crs_cmd_t c, logic [3:0] m,
                                             logic opt);
    crs_resets_t r;
    r = `CRS_RUN_RESETS;
    case (c)
      CMD_FULL_POWERON:
      begin
        r = `CRS_POR_RESETS;
        if (!opt)
        begin
          r.core_logic_reset_n = 4'hf;
          r.simd_fp_unit_reset_n = 4'hf;
          r.core_debug_reset_n = 4'hf;
        end
      end
      CMD_CORE_POWERON,
      CMD_CORE_POWERON_APB:
      begin
        r.core_poweron_reset_n = ~m;
        if (opt)
        begin
          r.core_logic_reset_n = ~m;
          r.simd_fp_unit_reset_n = ~m;
          r.core_debug_reset_n = ~m;
        end
        r.debug_apb_reset_n = (c != CMD_CORE_POWERON_APB);
      end
      CMD_SOFT_ALL,
      CMD_SOFT_CORE:
      begin
        r.core_logic_reset_n = ~m;
        if (opt)
        begin
          r.simd_fp_unit_reset_n = ~m;
        end
      end
      CMD_UNIT:
      begin
        r.simd_fp_unit_reset_n = ~m;
      end
      CMD_UNIT_APB:
      begin
        r.simd_fp_unit_reset_n = ~m;
        r.debug_apb_reset_n = 1'b0;
      end
      CMD_UNIT_DEBUG:
      begin
        r.simd_fp_unit_reset_n = ~m;
        r.core_debug_reset_n = ~m;
      end
      CMD_CORE_DEBUG:
      begin
        r.core_debug_reset_n = ~m;
      end
      CMD_DEBUG_ALL:
      begin
        r.core_debug_reset_n = 4'h0;
        r.debug_apb_reset_n = 1'b0;
      end
      CMD_APB:
      begin
        r.debug_apb_reset_n = 1'b0;
      end
      default:
      begin
        r = `CRS_RUN_RESETS;
      end
    endcase
    if (!UNIT_PRESENT)
    begin
      r.simd_fp_unit_reset_n = 4'hf;
    end
    return r;
  endfunction

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------

  crs_state_t state;
  crs_state_t next_state;
  crs_resets_t resets;
  crs_resets_t next_resets;
  crs_resets_t pend;
  crs_resets_t next_pend;
  logic [3:0] mask_q;
  logic [3:0] next_mask_q;
  logic soft_q;
  logic next_soft_q;
  logic dbg_used;
  logic next_dbg_used;
  logic por_auto;
  logic next_por_auto;
  logic done;
  logic next_done;
  logic refused;
  logic next_refused;
  logic dbg_q;
  logic dbg_edge;
  logic [`CRS_CNT_W-1:0] core_cnt;
  logic core_done;
  logic dbg_done;
  logic [3:0] req_mask;
  crs_resets_t req_pat;
  logic req_soft;
  logic bad;

  // ----------------------------------------------------------------
  // Minimum-width timers
  // ----------------------------------------------------------------

  // Debug clock is sampled as a level; its rising edges pace the timer
  assign dbg_edge = debug_apb_clock_i & ~dbg_q;

  crs_hold_timer #(
    .CW(`CRS_CNT_W),
    .LIMIT(`CRS_CORE_MIN_CYC)
  ) u_core_timer (
    .clk_i(clk_i),
    .sys_rst_i(sys_rst_i),
    .run_i(state == ST_HOLD),
    .tick_i(1'b1),
    .count_o(core_cnt),
    .done_o(core_done)
  );

  crs_hold_timer #(
    .CW(`CRS_CNT_W),
    .LIMIT(`CRS_DBG_EDGES)
  ) u_dbg_timer (
    .clk_i(clk_i),
    .sys_rst_i(sys_rst_i),
    .run_i(state == ST_HOLD),
    .tick_i(dbg_edge),
    .count_o(),
    .done_o(dbg_done)
  );

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------

  assign req_mask = mask_of(cmd_i, core_sel_i);
  assign req_pat = pattern_of(cmd_i, req_mask, opt_resets_i);
  assign req_soft = (cmd_i == CMD_SOFT_ALL) || (cmd_i == CMD_SOFT_CORE);

  always_comb
  begin
    bad = 1'b0;
    if ((cmd_i == CMD_FULL_POWERON) && (|core_active_i))
    begin
      bad = 1'b1;
    end
    if (!req_pat.debug_apb_reset_n && (|core_debugged_i))
    begin
      bad = 1'b1;
    end
    if (((cmd_i == CMD_CORE_POWERON) || (cmd_i == CMD_CORE_POWERON_APB))
        && ((core_powered_i & req_mask) != req_mask))
    begin
      bad = 1'b1;
    end
  end

  always_comb
  begin
    next_state = state;
    next_resets = resets;
    next_pend = pend;
    next_mask_q = mask_q;
    next_soft_q = soft_q;
    next_dbg_used = dbg_used;
    next_por_auto = por_auto;
    next_done = 1'b0;
    next_refused = 1'b0;
    case (state)
      ST_IDLE:
      begin
        next_resets = `CRS_RUN_RESETS;
        if (req_i && bad)
        begin
          next_refused = 1'b1;
        end
        else if (req_i)
        begin
          next_pend = req_pat;
          next_mask_q = req_mask;
          next_soft_q = req_soft;
          next_dbg_used = !req_pat.debug_apb_reset_n;
          if (req_soft)
          begin
            next_state = ST_WAIT;
          end
          else
          begin
            next_state = ST_HOLD;
            next_resets = req_pat;
          end
        end
      end
      ST_WAIT:
      begin
        // Preparation upstream may omit the coherency bit step
        // when SINGLE_CORE is set
        if (prep_done_i &&
            ((core_idle_standby_i & mask_q) == mask_q))
        begin
          next_state = ST_HOLD;
          next_resets = pend;
        end
      end
      ST_HOLD:
      begin
        // One release edge for every pin: shared cache never trails
        if (core_done && (dbg_done || !dbg_used))
        begin
          next_state = ST_IDLE;
          next_resets = `CRS_RUN_RESETS;
          next_por_auto = 1'b0;
          next_done = 1'b1;
        end
      end
      default:
      begin
        next_state = ST_IDLE;
        next_resets = `CRS_RUN_RESETS;
      end
    endcase
  end

  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i)
    begin
      state <= ST_HOLD;
      resets <= `CRS_POR_RESETS;
      pend <= `CRS_RUN_RESETS;
      mask_q <= `CRS_ALL_CORES;
      soft_q <= 1'b0;
      dbg_used <= 1'b1;
      por_auto <= 1'b1;
      done <= 1'b0;
      refused <= 1'b0;
      // High so a debug clock already high is not taken as an edge
      dbg_q <= 1'b1;
    end
    else
    begin
      state <= next_state;
      resets <= next_resets;
      pend <= next_pend;
      mask_q <= next_mask_q;
      soft_q <= next_soft_q;
      dbg_used <= next_dbg_used;
      por_auto <= next_por_auto;
      done <= next_done;
      refused <= next_refused;
      dbg_q <= debug_apb_clock_i;
    end
  end

  always_comb
  begin
    resets_o = resets;
    if (!UNIT_PRESENT)
    begin
      resets_o.simd_fp_unit_reset_n = 4'hf;
    end
  end

  assign clamp_release_o = (state == ST_HOLD) && soft_q &&
                           (core_cnt >= `CRS_CLAMP_CYC);
  assign busy_o = (state != ST_IDLE);
  assign done_o = done;
  assign refused_o = refused;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------

  logic [7:0] a_low_cnt;
  logic [7:0] a_dbg_cnt;

  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i)
    begin
      a_low_cnt <= 8'h00;
      a_dbg_cnt <= 8'h00;
    end
    else
    begin
      if (resets_o != `CRS_RUN_RESETS && a_low_cnt != 8'hff)
        a_low_cnt <= 8'(a_low_cnt + 1'b1);
      else if (resets_o == `CRS_RUN_RESETS)
        a_low_cnt <= 8'h00;
      if (!resets_o.debug_apb_reset_n && dbg_edge && a_dbg_cnt != 8'hff)
        a_dbg_cnt <= 8'(a_dbg_cnt + 1'b1);
      else if (resets_o.debug_apb_reset_n)
        a_dbg_cnt <= 8'h00;
    end
  end

  idle_all_high_a: assert property (
    @(posedge clk_i) disable iff (sys_rst_i)
    (state == ST_IDLE) |-> (resets_o == `CRS_RUN_RESETS))
    else $error("reset pin low while idle");

  hold_length_a: assert property (
    @(posedge clk_i) disable iff (sys_rst_i)
    (resets_o != `CRS_RUN_RESETS) ##1 (resets_o == `CRS_RUN_RESETS)
    |-> ($past(a_low_cnt) >= `CRS_HOLD_LAST))
    else $error("reset released before 16 core cycles");

  dbg_length_a: assert property (
    @(posedge clk_i) disable iff (sys_rst_i)
    $rose(resets_o.debug_apb_reset_n)
    |-> ($past(a_dbg_cnt) >= `CRS_DBG_MIN_CYC))
    else $error("debug APB reset released too early");

  cache_order_a: assert property (
    @(posedge clk_i) disable iff (sys_rst_i)
    $rose(&resets_o.core_poweron_reset_n)
    |-> resets_o.shared_cache_reset_n)
    else $error("shared cache released after core power-on reset");

  cache_guard_a: assert property (
    @(posedge clk_i) disable iff (sys_rst_i)
    $fell(resets_o.shared_cache_reset_n)
    |-> ($past(core_active_i) == 4'h0))
    else $error("shared cache reset asserted with a core active");

  apb_guard_a: assert property (
    @(posedge clk_i) disable iff (sys_rst_i)
    $fell(resets_o.debug_apb_reset_n)
    |-> ($past(core_debugged_i) == 4'h0))
    else $error("debug APB reset asserted while debugging");

  soft_wait_a: assert property (
    @(posedge clk_i) disable iff (sys_rst_i)
    (state == ST_WAIT) ##1 (state == ST_HOLD)
    |-> (($past(core_idle_standby_i) & mask_q) == mask_q) && $past(prep_done_i))
    else $error("soft reset without idle indicator");

  clamp_time_a: assert property (
    @(posedge clk_i) disable iff (sys_rst_i)
    $rose(clamp_release_o)
    |-> ($past(resets_o.core_logic_reset_n, 5) == ~mask_q) &&
        (resets_o.core_logic_reset_n == ~mask_q))
    else $error("clamps released before 5 cycles of reset");

  soft_pair_a: assert property (
    @(posedge clk_i) disable iff (sys_rst_i)
    (state == ST_HOLD) && soft_q && (resets_o.simd_fp_unit_reset_n != 4'hf)
    |-> (resets_o.simd_fp_unit_reset_n == resets_o.core_logic_reset_n))
    else $error("unit and core soft resets differ");

  unit_absent_a: assert property (
    @(posedge clk_i) disable iff (sys_rst_i)
    !UNIT_PRESENT |-> (resets_o.simd_fp_unit_reset_n == 4'hf))
    else $error("absent unit reset driven low");

endmodule
`default_nettype wire

// ===== verilog/crs_params.svh
// Timing counts and reset patterns for the cluster reset sequencer
`ifndef CRS_PARAMS_SVH
`define CRS_PARAMS_SVH

// Least hold of a core-clock reset, in core-clock cycles
`define CRS_CORE_MIN_CYC 5'h10
// Debug-clock rising edges counted so 16 full debug periods elapse
`define CRS_DBG_EDGES 5'h11
// Least debug-clock periods for the debug APB reset
`define CRS_DBG_MIN_CYC 8'h10
// Cycles of asserted core reset before clamps may be released
`define CRS_CLAMP_CYC 5'h05
// Low-cycle count seen in the last low cycle of a 16-cycle hold
`define CRS_HOLD_LAST 8'h0f
// Width of the hold counters
`define CRS_CNT_W 5
// Every reset asserted: state of the pins at power arrival
`define CRS_POR_RESETS 18'h00000
// Every reset released: run mode
`define CRS_RUN_RESETS 18'h3ffff
// All four cores selected
`define CRS_ALL_CORES 4'hf

`endif

// ===== verilog/crs_pkg.sv
// Types shared by the cluster reset sequencer
`default_nettype none
package crs_pkg;

  // The six reset pins, all active low, per-core fields indexed by core
  typedef struct packed {
    logic [3:0] core_poweron_reset_n;
    logic [3:0] core_logic_reset_n;
    logic [3:0] simd_fp_unit_reset_n;
    logic [3:0] core_debug_reset_n;
    logic debug_apb_reset_n;
    logic shared_cache_reset_n;
  } crs_resets_t;

  typedef enum logic [3:0] {
    CMD_FULL_POWERON,
    CMD_CORE_POWERON,
    CMD_CORE_POWERON_APB,
    CMD_SOFT_ALL,
    CMD_SOFT_CORE,
    CMD_UNIT,
    CMD_UNIT_APB,
    CMD_UNIT_DEBUG,
    CMD_CORE_DEBUG,
    CMD_DEBUG_ALL,
    CMD_APB
  } crs_cmd_t;

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_WAIT,
    ST_HOLD
  } crs_state_t;

endpackage
`default_nettype wire

// ===== verilog/crs_hold_timer.sv
// Saturating minimum-width timer for one reset hold
`default_nettype none
module crs_hold_timer #(
  parameter int CW = 5,
  parameter logic [CW-1:0] LIMIT = 5'h10
) (
  input wire logic clk_i,
  input wire logic sys_rst_i,
  input wire logic run_i,
  input wire logic tick_i,
  output logic [CW-1:0] count_o,
  output logic done_o
);

  logic [CW-1:0] count;
  logic [CW-1:0] next_count;

  always_comb
  begin
    next_count = count;
    if (!run_i)
    begin
      next_count = '0;
    end
    else if (tick_i && (count < LIMIT))
    begin
      next_count = CW'(count + 1'b1);
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i)
    begin
      count <= '0;
    end
    else
    begin
      count <= next_count;
    end
  end

  assign count_o = count;
  assign done_o = (count >= LIMIT);

endmodule
`default_nettype wire

// ===== bench/crs_cluster_model.sv
// Behavioural model of the processor cluster driven by the sequencer
`default_nettype none
module crs_cluster_model
  import crs_pkg::*;
(
  input wire logic clk_i,
  input wire logic debug_apb_clock_i,
  input wire crs_resets_t resets_i,
  input wire logic [3:0] sleep_i,
  input wire logic [3:0] active_i,
  input wire logic [3:0] debugged_i,
  output logic [3:0] idle_o,
  output logic [3:0] dbg_reset_o,
  output logic held_o,
  output logic viol_o
);
  timeunit 1ns;
  timeprecision 100ps;
  // --------------------------------
  // Domain state and width checks
  // --------------------------------
  logic [16:0] cur;
  logic [16:0] prev = '0;
  logic [4:0] cnt [17] = '{default: 5'h00};
  logic [4:0] acnt = 5'h00;
  logic aprev = 1'b0;
  logic [3:0] d1 = 4'h0;
  logic [3:0] d2 = 4'h0;
  logic [3:0] idle = 4'h0;
  logic vc = 1'b0;
  logic vd = 1'b0;
  assign cur = {resets_i[17:2], resets_i[0]};
  assign held_o = ~&resets_i;
  assign dbg_reset_o = ~(resets_i.core_poweron_reset_n
    & resets_i.core_debug_reset_n);
  assign idle_o = idle;
  assign viol_o = vc | vd;
  // Idle indicator lags the sleep request by three cycles
  always @(posedge clk_i)
  begin
    d1 <= sleep_i;
    d2 <= d1;
    idle <= d2;
    for (int i = 0; i < 17; i++)
    begin
      cnt[i] <= (cur[i] !== 1'b0) ? 5'h00 : cnt[i] + {4'h0, cnt[i] != 5'h1f};
      if (!prev[i] && cur[i] && cnt[i] < 5'h10)
        vc <= 1'b1;
    end
    if (!cur[0] && (|(~prev[16:1] & cur[16:1])))
      vc <= 1'b1;
    if (prev[0] && !cur[0] && (|active_i))
      vc <= 1'b1;
    prev <= cur;
  end
  always @(posedge debug_apb_clock_i)
  begin
    acnt <= (resets_i.debug_apb_reset_n !== 1'b0) ? 5'h00
      : acnt + {4'h0, acnt != 5'h1f};
    if (resets_i.debug_apb_reset_n && !aprev && acnt < 5'h10)
      vd <= 1'b1;
    if (aprev && !resets_i.debug_apb_reset_n && (|debugged_i))
      vd <= 1'b1;
    aprev <= resets_i.debug_apb_reset_n;
  end
endmodule
`default_nettype wire

// ===== bench/test_crs_reset_sequencer.sv
// Self-checking testbench for the cluster reset sequencer
`include "crs_params.svh"
`default_nettype none
module test_crs_reset_sequencer
  import crs_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk = 1'b0;
  logic dclk = 1'b0;
  logic rst = 1'b1;
  logic req = 1'b0;
  crs_cmd_t cmd = CMD_APB;
  logic [1:0] sel = 2'h0;
  logic opt = 1'b0;
  logic [3:0] active = 4'h0;
  logic [3:0] debugged = 4'h0;
  logic [3:0] powered = 4'hf;
  logic [3:0] sleep = 4'h0;
  logic prep = 1'b0;
  crs_resets_t resets;
  crs_resets_t last;
  logic clamp, busy, done, refused, viol, held;
  logic [3:0] idle, dbgrst;
  int low;
  int n_mismatch = 0;
  int total_checks = 0;

  initial
  begin
    forever #2.5 clk = ~clk;
  end
  initial
  begin
    forever #9.3 dclk = ~dclk;
  end

  crs_reset_sequencer uut (
    .clk_i(clk), .sys_rst_i(rst), .debug_apb_clock_i(dclk),
    .req_i(req), .cmd_i(cmd), .core_sel_i(sel), .opt_resets_i(opt),
    .core_active_i(active), .core_debugged_i(debugged),
    .core_powered_i(powered), .core_idle_standby_i(idle),
    .prep_done_i(prep), .resets_o(resets), .clamp_release_o(clamp),
    .busy_o(busy), .done_o(done), .refused_o(refused)
  );
  crs_cluster_model model (
    .clk_i(clk), .debug_apb_clock_i(dclk), .resets_i(resets),
    .sleep_i(sleep), .active_i(active), .debugged_i(debugged),
    .idle_o(idle), .dbg_reset_o(dbgrst), .held_o(held), .viol_o(viol)
  );

  // --------------------------------
  // Reporting and comparison
  // --------------------------------
  task automatic results();
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task automatic miss(input string m);
    n_mismatch++;
    $display("unexpected at %0t: %s", $time, m);
  endtask
  task automatic chk_res(input crs_resets_t g, input crs_resets_t e);
    total_checks++;
    if (g !== e)
      miss($sformatf("resets %h want %h", g, e));
  endtask
  task automatic chk_bit(input logic g, input logic e, input string m);
    total_checks++;
    if (g !== e)
      miss(m);
  endtask
  task automatic chk_cnt(input int g, input int lo, input int hi,
    input string m);
    total_checks++;
    if (g < lo || g > hi)
      miss($sformatf("%s count %0d", m, g));
  endtask

  // --------------------------------
  // Expected patterns and drivers
  // --------------------------------
  function automatic crs_resets_t exp_pat(crs_cmd_t c, logic [1:0] s,
    logic o);
    crs_resets_t r;
    logic [3:0] m;
    r = `CRS_RUN_RESETS;
    m = 4'h1 << s;
    if (c == CMD_FULL_POWERON || c == CMD_SOFT_ALL || c == CMD_DEBUG_ALL)
      m = `CRS_ALL_CORES;
    case (c)
      CMD_FULL_POWERON, CMD_CORE_POWERON, CMD_CORE_POWERON_APB:
      begin
        r.core_poweron_reset_n = ~m;
        if (o)
        begin
          r.core_logic_reset_n = ~m;
          r.simd_fp_unit_reset_n = ~m;
          r.core_debug_reset_n = ~m;
        end
        r.shared_cache_reset_n = (c != CMD_FULL_POWERON);
        r.debug_apb_reset_n = (c == CMD_CORE_POWERON);
      end
      CMD_SOFT_ALL, CMD_SOFT_CORE:
      begin
        r.core_logic_reset_n = ~m;
        if (o)
          r.simd_fp_unit_reset_n = ~m;
      end
      CMD_UNIT, CMD_UNIT_APB, CMD_UNIT_DEBUG:
      begin
        r.simd_fp_unit_reset_n = ~m;
        r.debug_apb_reset_n = (c != CMD_UNIT_APB);
        if (c == CMD_UNIT_DEBUG)
          r.core_debug_reset_n = ~m;
      end
      CMD_CORE_DEBUG, CMD_DEBUG_ALL:
      begin
        r.core_debug_reset_n = ~m;
        r.debug_apb_reset_n = (c != CMD_DEBUG_ALL);
      end
      default:
        r.debug_apb_reset_n = 1'b0;
    endcase
    return r;
  endfunction
  // Called at a falling edge; returns in the first cycle after the take
  task automatic issue(input crs_cmd_t c, input logic [1:0] s, input logic o);
    req = 1'b1;
    cmd = c;
    sel = s;
    opt = o;
    @(negedge clk);
    req = 1'b0;
  endtask
  // Counts low cycles up to release, keeps the last held pattern
  task automatic hold(input int start);
    low = start;
    while (resets !== `CRS_RUN_RESETS)
    begin
      last = resets;
      @(negedge clk);
      low++;
      if (low > 900)
      begin
        miss("release timeout");
        results();
      end
    end
    low--;
    chk_bit(done, 1'b1, "no done pulse");
    chk_bit(busy, 1'b0, "busy after release");
  endtask

  // --------------------------------
  // Scenarios
  // --------------------------------
  task automatic t_table();
    crs_cmd_t cl [9] = '{CMD_CORE_POWERON, CMD_CORE_POWERON_APB, CMD_UNIT,
      CMD_UNIT_APB, CMD_UNIT_DEBUG, CMD_CORE_DEBUG, CMD_DEBUG_ALL, CMD_APB,
      CMD_FULL_POWERON};
    crs_resets_t e;
    for (int k = 0; k < 9; k++)
    begin
      e = exp_pat(cl[k], k[1:0], k[0]);
      issue(cl[k], k[1:0], k[0]);
      chk_res(resets, e);
      chk_bit(busy, 1'b1, "not busy after accept");
      hold(1);
      chk_res(last, e);
      if (e.debug_apb_reset_n)
        chk_cnt(low, 17, 17, "core hold");
      else
        chk_cnt(low, 17, 900, "debug hold");
      chk_bit(viol, 1'b0, "cluster saw a fault");
    end
  endtask
  task automatic t_refuse();
    crs_cmd_t rc [3] = '{CMD_FULL_POWERON, CMD_UNIT_APB, CMD_CORE_POWERON};
    for (int k = 0; k < 3; k++)
    begin
      active = (k == 0) ? 4'h4 : 4'h0;
      debugged = (k == 1) ? 4'h2 : 4'h0;
      powered = (k == 2) ? 4'hb : 4'hf;
      issue(rc[k], 2'h2, 1'b0);
      chk_bit(refused, 1'b1, "no refusal");
      chk_res(resets, `CRS_RUN_RESETS);
      @(negedge clk);
      chk_bit(refused, 1'b0, "refusal too long");
    end
    active = 4'h0;
    debugged = 4'h0;
    powered = 4'hf;
  endtask
  task automatic t_soft(input crs_cmd_t c, input logic [1:0] s,
    input logic o);
    crs_resets_t e;
    int w;
    e = exp_pat(c, s, o);
    prep = 1'b1;
    issue(c, s, o);
    repeat (6) @(negedge clk);
    chk_res(resets, `CRS_RUN_RESETS);
    chk_bit(busy, 1'b1, "not waiting for idle");
    sleep = ~e.core_logic_reset_n;
    w = 0;
    while (resets === `CRS_RUN_RESETS && w < 40)
    begin
      @(negedge clk);
      w++;
    end
    if (w >= 40)
    begin
      miss("idle wait timeout");
      results();
    end
    chk_cnt(w, 4, 4, "idle wait");
    chk_res(resets, e);
    chk_bit(dbgrst[s], 1'b0, "debug domain reset");
    repeat (4) @(negedge clk);
    chk_bit(clamp, 1'b0, "clamp released early");
    @(negedge clk);
    chk_bit(clamp, 1'b1, "clamp not released");
    sleep = 4'h0;
    prep = 1'b0;
    hold(6);
    chk_res(last, e);
    chk_cnt(low, 17, 17, "soft hold");
    chk_bit(viol, 1'b0, "cluster saw a fault");
  endtask

  initial
  begin
    repeat (4) @(negedge clk);
    rst = 1'b0;
    @(negedge clk);
    chk_res(resets, `CRS_POR_RESETS);
    chk_bit(busy, 1'b1, "not busy in power-on");
    hold(1);
    chk_cnt(low, 17, 900, "power-on hold");
    chk_bit(held, 1'b0, "logic held in run mode");
    chk_bit(viol, 1'b0, "cluster saw a fault");
    t_table();
    t_refuse();
    t_soft(CMD_SOFT_CORE, 2'h1, 1'b1);
    t_soft(CMD_SOFT_ALL, 2'h0, 1'b0);
    results();
  end
endmodule
`default_nettype wire
